//--- rpds_pkg.sv
// Package for the reset and power-down sequencer: timing figures, cycle counts, states and carriers.
// Assumes a single 25 MHz clock.
`default_nettype none
package rpds_pkg;
    // Clock period in nanoseconds.
    localparam int CLK_PERIOD_NS = 40;
    // Delay from reset falling to power-stage enable low, in ns.
    localparam int RESET_VALID_LOW_NS = 300;
    localparam int RESET_VALID_LOW_CYC = RESET_VALID_LOW_NS / CLK_PERIOD_NS;
    // Least reset pulse, in ms, and its cycle count rounded up.
    localparam int RESET_PULSE_MS = 1;
    localparam int RESET_PULSE_CYC = (RESET_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Time from reset release to control port ready, in us (3.5 ms).
    localparam int CTRL_READY_US = 3500;
    localparam int CTRL_READY_CYC = CTRL_READY_US * 1000 / CLK_PERIOD_NS;
    // Least run delay after the start-up command, in ms, rounded up.
    localparam int RUN_DELAY_MS = 10;
    localparam int RUN_DELAY_CYC = (RUN_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Delay from power-down assertion to enable low, in us.
    localparam int PDN_VALID_LOW_US = 725;
    localparam int PDN_VALID_LOW_CYC = PDN_VALID_LOW_US * 1000 / CLK_PERIOD_NS;
    // Start-up time after power-down release, in ms.
    localparam int PDN_STARTUP_MS = 120;
    localparam int PDN_STARTUP_CYC = PDN_STARTUP_MS * 1000000 / CLK_PERIOD_NS;
    // Least power-down pulse, in ns, rounded up.
    localparam int PDN_PULSE_NS = 800;
    localparam int PDN_PULSE_CYC = (PDN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Counter width wide enough for the longest interval.
    localparam int CNT_W = 23;
    // Sequencer states.
    typedef enum logic [2:0] {
        RPDS_RUN,
        RPDS_RST_WAIT,
        RPDS_IN_RESET,
        RPDS_CTRL_WAIT,
        RPDS_IDLE,
        RPDS_RUN_WAIT,
        RPDS_PDN_WAIT,
        RPDS_POWERED_DOWN
    } rpds_state_t;
    // Status outputs travelling together.
    typedef struct packed {
        logic valid;
        logic ctrl_ready;
        logic running;
        logic powered_down;
    } rpds_status_t;
endpackage : rpds_pkg
`default_nettype wire

//--- rpds_timer.sv
// Loadable down-counter that flags when a started interval has run out.
// Assumes synchronous active-high reset.
`default_nettype none
module rpds_timer #(
    parameter int W = 23
) (
    input wire logic clk, // Clock.
    input wire logic srst, // Synchronous reset.
    input wire logic load, // Starts an interval.
    input wire logic [W-1:0] count, // Interval length in cycles.
    output logic done // High while no interval is pending.
);
    // Remaining cycles.
    logic [W-1:0] cnt_q;
    // Counts down to zero after each load.
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    // Done when count has reached zero and no load is in progress.
    assign done = (cnt_q == '0) && !load;
endmodule : rpds_timer
`default_nettype wire

//--- rpds_sequencer.sv
// Reset and power-down sequencer for the amplifier's power stage.
// Assumes pins synchronous to REF_CLK and a controller keeping its pulse widths.
// Contract
// - Reset low drops enable after 300 ns.
// - Control port ready 3.5 ms after reset.
// - Run needs 10 ms after start-up command.
// - Power-down drops enable 725 us; 120 ms restart.
// - Power-down ignored while in reset.
// - Reset ignored while powered down.
`default_nettype none
module rpds_sequencer #(
    parameter int RESET_PULSE_CYC = rpds_pkg::RESET_PULSE_CYC, // Reset pulse to be taken.
    parameter int CTRL_READY_CYC = rpds_pkg::CTRL_READY_CYC, // Reset release to port ready.
    parameter int RUN_DELAY_CYC = rpds_pkg::RUN_DELAY_CYC, // Start-up command to run.
    parameter int PDN_VALID_LOW_CYC = rpds_pkg::PDN_VALID_LOW_CYC, // Power-down to enable low.
    parameter int PDN_STARTUP_CYC = rpds_pkg::PDN_STARTUP_CYC // Power-down release to run.
) (
    input wire logic REF_CLK, // System clock, 25 MHz.
    input wire logic SRST, // Synchronous reset, active high.
    input wire logic RESET_N, // Reset pin, active low.
    input wire logic POWER_DOWN_N, // Power-down pin, active low.
    input wire logic STARTUP_CMD, // One-cycle start-up command from the control port.
    output logic VALID, // Power-stage enable.
    output logic CTRL_READY, // Control port usable.
    output logic RUNNING, // Normal operation.
    output logic POWERED_DOWN // In powered-down state.
);
    // Current state.
    rpds_pkg::rpds_state_t state_q;
    // Next state.
    rpds_pkg::rpds_state_t state_d;
    // Status register driving the outputs.
    rpds_pkg::rpds_status_t stat_q;
    // Status next value.
    rpds_pkg::rpds_status_t stat_d;
    // Short delay counter for reset-to-enable-low.
    logic [3:0] rst_dly_q;
    // Loads the interval timer.
    logic tmr_load;
    // Interval length handed to the timer.
    logic [rpds_pkg::CNT_W-1:0] tmr_count;
    // High once the loaded interval has run out.
    logic tmr_done;
    // Cycles spent in the port-ready wait, watched by the ready-timing assertion.
    logic [rpds_pkg::CNT_W-1:0] ready_age_q;

    // Shared interval timer.
    rpds_timer #(.W(rpds_pkg::CNT_W)) u_timer (
        .clk(REF_CLK),
        .srst(SRST),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Counts cycles since reset fell, held at zero otherwise.
    always_ff @(posedge REF_CLK) begin
        if (SRST || state_q != rpds_pkg::RPDS_RST_WAIT) begin
            rst_dly_q <= '0;
        end else if (rst_dly_q != 4'hF) begin
            rst_dly_q <= rst_dly_q + 4'h1;
        end
    end

    // Counts up through the port-ready wait and clears in every other state.
    always_ff @(posedge REF_CLK) begin
        if (SRST || state_q != rpds_pkg::RPDS_CTRL_WAIT) begin
            ready_age_q <= '0;
        end else begin
            ready_age_q <= ready_age_q + 1'b1;
        end
    end

    // Next-state logic and timer loads.
    always_comb begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_count = '0;
        case (state_q)
            rpds_pkg::RPDS_RUN, rpds_pkg::RPDS_IDLE, rpds_pkg::RPDS_RUN_WAIT, rpds_pkg::RPDS_CTRL_WAIT: begin
                if (!RESET_N) begin
                    // Reset has priority over power-down when both arrive.
                    state_d = rpds_pkg::RPDS_RST_WAIT;
                end else if (!POWER_DOWN_N) begin
                    state_d = rpds_pkg::RPDS_PDN_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = rpds_pkg::CNT_W'(PDN_VALID_LOW_CYC - 1);
                end else if (state_q == rpds_pkg::RPDS_CTRL_WAIT && tmr_done) begin
                    state_d = rpds_pkg::RPDS_IDLE;
                end else if (state_q == rpds_pkg::RPDS_IDLE && STARTUP_CMD) begin
                    state_d = rpds_pkg::RPDS_RUN_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = rpds_pkg::CNT_W'(RUN_DELAY_CYC);
                end else if (state_q == rpds_pkg::RPDS_RUN_WAIT && tmr_done) begin
                    state_d = rpds_pkg::RPDS_RUN;
                end
            end
            rpds_pkg::RPDS_RST_WAIT: begin
                // Enable drops once the short delay has run.
                if (rst_dly_q >= 4'(rpds_pkg::RESET_VALID_LOW_CYC - 1)) begin
                    state_d = rpds_pkg::RPDS_IN_RESET;
                end
            end
            rpds_pkg::RPDS_IN_RESET: begin
                // Power-down is not looked at here.
                if (RESET_N) begin
                    state_d = rpds_pkg::RPDS_CTRL_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = rpds_pkg::CNT_W'(CTRL_READY_CYC);
                end
            end
            rpds_pkg::RPDS_PDN_WAIT: begin
                // Reset is not looked at while going down.
                if (tmr_done) begin
                    state_d = rpds_pkg::RPDS_POWERED_DOWN;
                end
            end
            rpds_pkg::RPDS_POWERED_DOWN: begin
                // Reset is ignored; only release of power-down leaves.
                if (POWER_DOWN_N) begin
                    state_d = rpds_pkg::RPDS_RUN_WAIT;
                    tmr_load = 1'b1;
                    tmr_count = rpds_pkg::CNT_W'(PDN_STARTUP_CYC);
                end
            end
            default: begin
                state_d = rpds_pkg::RPDS_RST_WAIT;
            end
        endcase
    end

    // State register.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            state_q <= rpds_pkg::RPDS_IN_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Output decode from the next state so outputs come straight from flops.
    always_comb begin
        // The delay states only keep an enable that was already high, so a wait state never raises it.
        stat_d.valid = (state_d == rpds_pkg::RPDS_RUN) || (stat_q.valid
            && ((state_d == rpds_pkg::RPDS_RST_WAIT) || (state_d == rpds_pkg::RPDS_PDN_WAIT)));
        stat_d.ctrl_ready = (state_d == rpds_pkg::RPDS_IDLE) || (state_d == rpds_pkg::RPDS_RUN_WAIT)
            || (state_d == rpds_pkg::RPDS_RUN);
        stat_d.running = (state_d == rpds_pkg::RPDS_RUN);
        stat_d.powered_down = (state_d == rpds_pkg::RPDS_POWERED_DOWN);
    end

    // Status register.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    // Outputs are straight copies of the status flops.
    assign VALID = stat_q.valid;
    assign CTRL_READY = stat_q.ctrl_ready;
    assign RUNNING = stat_q.running;
    assign POWERED_DOWN = stat_q.powered_down;

    // Reset low in run drops the enable within 1 to 10 cycles.
    rst_drop_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_RUN && !RESET_N) |-> ##[1:10] !VALID)
        else $error("Enable did not drop after reset.");
    // Powered-down state ignores reset.
    pdn_holds_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_POWERED_DOWN && !POWER_DOWN_N && !RESET_N)
        |=> state_q == rpds_pkg::RPDS_POWERED_DOWN)
        else $error("Reset disturbed powered-down state.");
    // In reset, power-down is ignored.
    rst_holds_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_IN_RESET && !RESET_N) |=> state_q == rpds_pkg::RPDS_IN_RESET)
        else $error("Power-down disturbed reset state.");
    // Enable never high while waiting to start.
    valid_low_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_RUN_WAIT || state_q == rpds_pkg::RPDS_CTRL_WAIT) |-> !VALID)
        else $error("Enable high before start-up done.");
    // Port not ready straight after reset release.
    ctrl_wait_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        $rose(RESET_N) && state_q == rpds_pkg::RPDS_IN_RESET |=> !CTRL_READY [*2])
        else $error("Control port ready too early.");
    // Run not reached right after start-up command.
    run_wait_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_IDLE && STARTUP_CMD && RESET_N && POWER_DOWN_N) |=> !RUNNING [*2])
        else $error("Running too early after command.");
    // Power-down from run keeps enable high for the next two cycles.
    pdn_entry_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_RUN && RESET_N && !POWER_DOWN_N) |=> VALID [*2])
        else $error("Enable dropped too early on power-down.");
    // Running implies enable high.
    run_valid_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        RUNNING |-> VALID)
        else $error("Running without enable.");
    // The enable only ever rises together with normal operation.
    valid_rise_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        $rose(VALID) |-> RUNNING)
        else $error("Enable rose outside normal operation.");
    // The control port opens only after the full ready wait has been spent.
    ready_time_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        $rose(CTRL_READY) && $past(state_q) == rpds_pkg::RPDS_CTRL_WAIT |-> ready_age_q >= rpds_pkg::CNT_W'(CTRL_READY_CYC))
        else $error("Control port opened before the ready wait.");
    // Release of power-down starts the restart wait with the enable still low.
    pdn_exit_a: assert property (@(posedge REF_CLK) disable iff (SRST)
        (state_q == rpds_pkg::RPDS_POWERED_DOWN && POWER_DOWN_N) |=> (state_q == rpds_pkg::RPDS_RUN_WAIT && !VALID))
        else $error("Power-down release did not start the restart wait.");
    // Main scenarios: run, powered down, port ready, reset while down, power-down from idle.
    run_c: cover property (@(posedge REF_CLK) RUNNING);
    rst_down_c: cover property (@(posedge REF_CLK) POWERED_DOWN && !RESET_N);
    pdn_idle_c: cover property (@(posedge REF_CLK) state_q == rpds_pkg::RPDS_IDLE && RESET_N && !POWER_DOWN_N);
    pdn_c: cover property (@(posedge REF_CLK) POWERED_DOWN);
    ready_c: cover property (@(posedge REF_CLK) $rose(CTRL_READY));
endmodule : rpds_sequencer
`default_nettype wire

//--- rpds_ctrl_model.sv
// Controller model that drives the sequencer's reset, power-down and start-up command pins.
// Assumes the bench calls its tasks, and that pins change only just after rising clock edges.
`default_nettype none
module rpds_ctrl_model (
    input wire logic clk, // Bench clock.
    output logic reset_n, // Reset pin, active low.
    output logic power_down_n, // Power-down pin, active low.
    output logic startup_cmd // Start-up command pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Reset is held low from time zero, so it covers the supply ramp-up.
    initial begin
        reset_n = 1'b0;
        power_down_n = 1'b1;
        startup_cmd = 1'b0;
    end
    // Sets one pin level just after a rising edge.
    task automatic set_pin(input bit power_down_pin, input logic v);
        @(posedge clk);
        if (power_down_pin) power_down_n <= v;
        else reset_n <= v;
    endtask : set_pin
    // Holds one pin low for a width the caller picks at or above its minimum.
    task automatic pulse(input bit power_down_pin, input int cycles);
        set_pin(power_down_pin, 1'b0);
        repeat (cycles) @(posedge clk);
        set_pin(power_down_pin, 1'b1);
    endtask : pulse
    // Puts one bit on the command line for one cycle.
    task automatic noise(input logic b);
        @(posedge clk);
        startup_cmd <= b;
    endtask : noise
    // Start-up command; the bench calls it only once the port is ready.
    task automatic command();
        noise(1'b1);
        noise(1'b0);
    endtask : command
endmodule : rpds_ctrl_model
`default_nettype wire

//--- test_reset_powerdown_sequencer.sv
// Self-checking bench for the reset and power-down sequencer with shortened intervals.
// Assumes the controller model drives all pins; VALID changes are checked against a queue.
`default_nettype none
module test_reset_powerdown_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CR = 20; // Port-ready wait.
    localparam int RD = 30; // Run delay after the command.
    localparam int PV = 10; // Power-down to enable low.
    localparam int PS = 40; // Power-down release to run.
    localparam int RP = 30; // Reset pulse width used.
    typedef struct {logic v; int lo; int hi;} rpds_note_t;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic reset_n;
    logic power_down_n;
    logic startup_cmd;
    rpds_pkg::rpds_status_t st;
    int errors = 0;
    int compares = 0;
    int cyc = 0;
    int t;
    logic prev_valid = 1'b0;
    logic [31:0] lfsr = 32'habae_32e1;
    rpds_note_t notes[$];
    // Clock and a cycle count that moves on the falling edge, so it is stable at rising edges.
    always #20 ref_clk = ~ref_clk;
    always @(negedge ref_clk) cyc <= cyc + 1;
    rpds_ctrl_model rpds_ctrl_model_i (.clk(ref_clk), .reset_n(reset_n), .power_down_n(power_down_n),
        .startup_cmd(startup_cmd));
    rpds_sequencer #(.RESET_PULSE_CYC(RP), .CTRL_READY_CYC(CR), .RUN_DELAY_CYC(RD), .PDN_VALID_LOW_CYC(PV),
        .PDN_STARTUP_CYC(PS)) rpds_sequencer_i (.REF_CLK(ref_clk), .SRST(srst), .RESET_N(reset_n),
        .POWER_DOWN_N(power_down_n), .STARTUP_CMD(startup_cmd), .VALID(st.valid), .CTRL_READY(st.ctrl_ready),
        .RUNNING(st.running), .POWERED_DOWN(st.powered_down));
    function automatic logic [31:0] next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check
    // Notes an expected VALID level and the cycle window in which it must appear.
    task automatic expect_valid(input logic v, input int lo, input int hi);
        notes.push_back('{v, cyc + lo, cyc + hi});
    endtask : expect_valid
    // Waits, bounded, until every noted VALID change has been seen.
    task automatic drain();
        for (int i = 0; i < 300 && notes.size() != 0; i++) @(negedge ref_clk);
        check("notes_left", 0, notes.size());
    endtask : drain
    // Waits for the port to become ready and checks how long it took.
    task automatic await_ready();
        t = cyc;
        for (int i = 0; i < 200 && st.ctrl_ready !== 1'b1; i++) @(negedge ref_clk);
        check("ready_delay", 1, cyc - t >= CR - 2 && cyc - t <= CR + 6);
    endtask : await_ready
    task automatic start_run();
        expect_valid(1'b1, RD - 2, RD + 6);
        rpds_ctrl_model_i.command();
        drain();
        check("running", 1, st.running);
    endtask : start_run
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    // Each VALID change takes the oldest note and is compared with it, value and window.
    always @(posedge ref_clk) begin
        rpds_note_t n;
        if (srst) prev_valid = 1'b0;
        else if (st.valid !== prev_valid) begin
            prev_valid = st.valid;
            if (notes.size() == 0) check("valid_unexpected", 0, 1);
            else begin
                n = notes.pop_front();
                check("valid", n.v, st.valid);
                check("valid_time", 1, cyc >= n.lo && cyc <= n.hi);
            end
        end
    end
    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge ref_clk);
        check("timeout", 0, 1);
        final_report();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        // Random commands while still in reset must be ignored.
        for (int i = 0; i < 10; i++) begin
            lfsr = next(lfsr);
            rpds_ctrl_model_i.noise(lfsr[0]);
        end
        rpds_ctrl_model_i.noise(1'b0);
        rpds_ctrl_model_i.set_pin(0, 1'b1);
        await_ready();
        lfsr = next(lfsr);
        repeat (lfsr[2:0]) @(posedge ref_clk);
        start_run();
        // Reset from run, with a power-down request inside it that must be ignored.
        expect_valid(1'b0, 5, 12);
        fork
            rpds_ctrl_model_i.pulse(0, RP);
            begin
                repeat (4) @(posedge ref_clk);
                rpds_ctrl_model_i.pulse(1, 21);
                @(negedge ref_clk);
                check("pdn_during_reset", 0, st.powered_down);
            end
        join
        drain();
        await_ready();
        check("pdn_in_reset", 0, st.powered_down);
        start_run();
        // Power-down from run, a reset pulse while down, then release.
        expect_valid(1'b0, PV - 2, PV + 6);
        rpds_ctrl_model_i.set_pin(1, 1'b0);
        drain();
        check("powered_down", 1, st.powered_down);
        check("ready_while_down", 0, st.ctrl_ready);
        rpds_ctrl_model_i.pulse(0, RP);
        @(negedge ref_clk);
        check("reset_while_down", 1, st.powered_down);
        expect_valid(1'b1, PS - 2, PS + 6);
        rpds_ctrl_model_i.set_pin(1, 1'b1);
        drain();
        check("restart_running", 1, st.running);
        check("down_released", 0, st.powered_down);
        // Reset from run, then a second reset inside the port-ready wait, which must leave the enable low.
        expect_valid(1'b0, 5, 12);
        rpds_ctrl_model_i.pulse(0, RP);
        drain();
        rpds_ctrl_model_i.pulse(0, RP);
        await_ready();
        // Power-down from the idle state must not raise the enable on its way down.
        rpds_ctrl_model_i.set_pin(1, 1'b0);
        repeat (PV + 4) @(negedge ref_clk);
        check("idle_down", 1, st.powered_down);
        expect_valid(1'b1, PS - 2, PS + 6);
        rpds_ctrl_model_i.set_pin(1, 1'b1);
        drain();
        check("idle_restart", 1, st.running);
        final_report();
    end
endmodule : test_reset_powerdown_sequencer
`default_nettype wire
